// ==== sapsel_startup.sv ====
// What this block does
// - drive bias into both address pins and digitise each with the 12-bit converter
// - bus address is twelve times high digit plus low digit, cut to 7 bits (sums above 127 wrap)
// - each pin code maps to a digit 0..11, larger resistance larger digit
// - a shorted pin, below lowest bin, forces address 126
// - an open pin, above highest bin, forces address 126
// - debug port off by default; shared pins serve sequencing, sync, power-good
// - boot-loader entry command in normal operation enables the debug port; one sent during start-up is ignored
// - blank configuration flash at power-up enables the debug port
// - invalid strap found at power-up enables the debug port
// - after supply passes threshold, run start-up delay then begin normal operation
// - external active-low reset held low keeps the device in reset
`timescale 1ns/1ps
`default_nettype none
`include "sapsel_params.svh"

module sapsel_startup #(
  parameter int STARTUP_CYC = `SAPSEL_STARTUP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        external_reset_low_input,
  input  wire logic        supply_above_threshold,
  input  wire logic        flash_blank,
  input  wire logic        bootload_cmd,
  output logic             bias_en_hi,
  output logic             bias_en_lo,
  output logic             adc_start,
  output logic             adc_sel_hi,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_code,
  output logic [6:0]       bus_addr,
  output logic             addr_valid,
  output logic             debug_port_en,
  output logic             shared_pins_func,
  output logic             run
);
  import sapsel_pkg::*;

  localparam int SETTLE = (`SAPSEL_SETTLE_CYC < 1) ? 1 : `SAPSEL_SETTLE_CYC;

  // ==========================================================
  // state
  sapsel_state_t state_ff,   nxt_state;
  logic [31:0]   cnt_ff,     nxt_cnt;
  logic          pin_ff,     nxt_pin;
  logic [11:0]   code_hi_ff, nxt_code_hi;
  logic [11:0]   code_lo_ff, nxt_code_lo;
  logic [6:0]    addr_ff,    nxt_addr;
  logic          valid_ff,   nxt_valid;
  logic          dbg_ff,     nxt_dbg;
  logic          bias_hi_ff, nxt_bias_hi;
  logic          bias_lo_ff, nxt_bias_lo;
  logic          start_ff,   nxt_start;
  logic          run_ff,     nxt_run;
  logic          blank_ff,   nxt_blank;
  logic          shared_ff,  nxt_shared;
  logic [6:0]    dec_addr;
  logic          dec_bad;
  logic          hold_rst;

  sapsel_addr_select u_sel (
    .code_hi   (code_hi_ff),
    .code_lo   (code_lo_ff),
    .addr      (dec_addr),
    .strap_bad (dec_bad)
  );

  // a held-low pin restarts the whole sequence synchronously
  assign hold_rst = !external_reset_low_input || !supply_above_threshold;

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_pin     = pin_ff;
    nxt_code_hi = code_hi_ff;
    nxt_code_lo = code_lo_ff;
    nxt_addr    = addr_ff;
    nxt_valid   = valid_ff;
    nxt_dbg     = dbg_ff;
    nxt_bias_hi = 1'b0;
    nxt_bias_lo = 1'b0;
    nxt_start   = 1'b0;
    nxt_run     = run_ff;
    nxt_blank   = blank_ff;
    unique case (state_ff)
      SAPSEL_ST_DELAY: begin
        if (cnt_ff >= 32'(STARTUP_CYC - 1)) begin
          nxt_state = SAPSEL_ST_BIAS;
          nxt_cnt   = 32'h0;
          nxt_pin   = 1'b1;
          nxt_blank = flash_blank;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      SAPSEL_ST_BIAS: begin
        nxt_bias_hi = pin_ff;
        nxt_bias_lo = !pin_ff;
        if (cnt_ff >= 32'(SETTLE - 1)) begin
          nxt_state = SAPSEL_ST_CONV;
          nxt_start = 1'b1;
          nxt_cnt   = 32'h0;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      SAPSEL_ST_CONV: begin
        nxt_bias_hi = pin_ff;
        nxt_bias_lo = !pin_ff;
        if (adc_done) begin
          if (pin_ff) begin
            nxt_code_hi = adc_code;
            nxt_pin     = 1'b0;
            nxt_state   = SAPSEL_ST_BIAS;
          end else begin
            nxt_code_lo = adc_code;
            nxt_state   = SAPSEL_ST_WAIT;
          end
        end
      end
      SAPSEL_ST_WAIT: begin
        // codes now registered; latch once and hold until reset
        nxt_addr  = dec_addr;
        nxt_valid = 1'b1;
        nxt_dbg   = dbg_ff || dec_bad || blank_ff;
        nxt_run   = 1'b1;
        nxt_state = SAPSEL_ST_RUN;
      end
      SAPSEL_ST_RUN: begin
        if (bootload_cmd) begin
          nxt_dbg = 1'b1;
        end
      end
    endcase
    if (hold_rst) begin
      nxt_state = SAPSEL_ST_DELAY;
      nxt_cnt   = 32'h0;
      nxt_valid = 1'b0;
      nxt_dbg   = 1'b0;
      nxt_run   = 1'b0;
      nxt_addr  = `SAPSEL_ADDR_FALLBACK;
      nxt_pin   = 1'b1;
      nxt_blank = 1'b0;
      // a cut sequence must not leave bias current or a start pulse behind
      nxt_bias_hi = 1'b0;
      nxt_bias_lo = 1'b0;
      nxt_start   = 1'b0;
    end
    // own flop so the pin-function output is registered, not an inverter
    nxt_shared = !nxt_dbg;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= SAPSEL_ST_DELAY;
      cnt_ff     <= 32'h0;
      pin_ff     <= 1'b1;
      code_hi_ff <= 12'h000;
      code_lo_ff <= 12'h000;
      addr_ff    <= `SAPSEL_ADDR_FALLBACK;
      valid_ff   <= 1'b0;
      dbg_ff     <= 1'b0;
      bias_hi_ff <= 1'b0;
      bias_lo_ff <= 1'b0;
      start_ff   <= 1'b0;
      run_ff     <= 1'b0;
      blank_ff   <= 1'b0;
      shared_ff  <= 1'b1;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      pin_ff     <= nxt_pin;
      code_hi_ff <= nxt_code_hi;
      code_lo_ff <= nxt_code_lo;
      addr_ff    <= nxt_addr;
      valid_ff   <= nxt_valid;
      dbg_ff     <= nxt_dbg;
      bias_hi_ff <= nxt_bias_hi;
      bias_lo_ff <= nxt_bias_lo;
      start_ff   <= nxt_start;
      run_ff     <= nxt_run;
      blank_ff   <= nxt_blank;
      shared_ff  <= nxt_shared;
    end
  end

  // ==========================================================
  // outputs
  assign bias_en_hi       = bias_hi_ff;
  assign bias_en_lo       = bias_lo_ff;
  assign adc_start        = start_ff;
  assign adc_sel_hi       = pin_ff;
  assign bus_addr         = addr_ff;
  assign addr_valid       = valid_ff;
  assign debug_port_en    = dbg_ff;
  assign shared_pins_func = shared_ff;
  assign run              = run_ff;

  // ==========================================================
  // assertions
  property p_addr_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (valid_ff && $past(valid_ff) && !hold_rst) |-> $stable(addr_ff);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed while held");

  property p_fallback;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_WAIT && dec_bad && !hold_rst) |=> (addr_ff == 7'h7E && dbg_ff);
  endproperty
  a_fallback: assert property (p_fallback) else $error("bad strap did not give 126 and debug");

  property p_combine;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_WAIT && !dec_bad && !hold_rst)
        |=> (addr_ff == 7'($past(u_sel.digit_hi) * 12 + $past(u_sel.digit_lo)));
  endproperty
  a_combine: assert property (p_combine) else $error("address is not 12*hi+lo");

  property p_ext_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      !external_reset_low_input |=> (!run_ff && !valid_ff && state_ff == SAPSEL_ST_DELAY);
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("not held in reset");

  property p_boot;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_RUN && bootload_cmd && !hold_rst) |=> dbg_ff;
  endproperty
  a_boot: assert property (p_boot) else $error("boot command did not enable debug port");

  property p_blank;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_WAIT && blank_ff && !hold_rst) |=> dbg_ff;
  endproperty
  a_blank: assert property (p_blank) else $error("blank flash did not enable debug port");

  property p_default_off;
    @(posedge ref_clk) disable iff (!rst_n)
      hold_rst |=> (!dbg_ff && shared_pins_func);
  endproperty
  a_default_off: assert property (p_default_off) else $error("debug port on during reset");

  property p_run_after_delay;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(run_ff) |-> $past(state_ff) == SAPSEL_ST_WAIT;
  endproperty
  a_run_after_delay: assert property (p_run_after_delay) else $error("run began outside sequence");

  property p_bias;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(start_ff) |-> (bias_hi_ff || bias_lo_ff);
  endproperty
  a_bias: assert property (p_bias) else $error("conversion without bias current");

  property p_shared_inverse;
    @(posedge ref_clk) disable iff (!rst_n)
      shared_ff == !dbg_ff;
  endproperty
  a_shared_inverse: assert property (p_shared_inverse) else $error("shared pins wrong");

  property p_invalid_strap;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_WAIT && dec_bad && !hold_rst) |=> dbg_ff;
  endproperty
  a_invalid_strap: assert property (p_invalid_strap) else $error("bad strap left debug off");

  property p_start_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      start_ff |=> !start_ff;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

  property p_bias_one_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      !(bias_hi_ff && bias_lo_ff);
  endproperty
  a_bias_one_pin: assert property (p_bias_one_pin) else $error("bias on both pins");

  property p_valid_stays;
    @(posedge ref_clk) disable iff (!rst_n)
      (valid_ff && !hold_rst) |=> valid_ff;
  endproperty
  a_valid_stays: assert property (p_valid_stays) else $error("address valid dropped");

  property p_dbg_stays;
    @(posedge ref_clk) disable iff (!rst_n)
      (dbg_ff && !hold_rst) |=> dbg_ff;
  endproperty
  a_dbg_stays: assert property (p_dbg_stays) else $error("debug port dropped");

  property p_delay_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_DELAY && cnt_ff < 32'(STARTUP_CYC - 1)) |=> state_ff == SAPSEL_ST_DELAY;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("start-up delay cut short");

  property p_run_valid;
    @(posedge ref_clk) disable iff (!rst_n)
      run_ff |-> valid_ff;
  endproperty
  a_run_valid: assert property (p_run_valid) else $error("run without address");

  property p_code_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == SAPSEL_ST_RUN && $past(state_ff) == SAPSEL_ST_RUN)
        |-> ($stable(code_hi_ff) && $stable(code_lo_ff));
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("pin codes changed in run");

  property p_reset_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      hold_rst |=> (!bias_hi_ff && !bias_lo_ff && !start_ff);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("bias or start during reset");
endmodule

`default_nettype wire

// ==== sapsel_params.svh ====
`ifndef SAPSEL_PARAMS_SVH
`define SAPSEL_PARAMS_SVH

// ==========================================================
// converter and address
`define SAPSEL_ADC_W          12
`define SAPSEL_ADDR_W         7
`define SAPSEL_DIGIT_W        4
`define SAPSEL_ADDR_MULT      7'h0C
`define SAPSEL_ADDR_FALLBACK  7'h7E
`define SAPSEL_NUM_BINS       12

// ==========================================================
// bin thresholds, midway between nominal strap voltages
// nominal code ~ 16 * R(kohm); short below, open above
`define SAPSEL_TH_SHORT       12'h240
`define SAPSEL_TH_0_1         12'h2D7
`define SAPSEL_TH_1_2         12'h34B
`define SAPSEL_TH_2_3         12'h3D1
`define SAPSEL_TH_3_4         12'h46A
`define SAPSEL_TH_4_5         12'h51B
`define SAPSEL_TH_5_6         12'h5E5
`define SAPSEL_TH_6_7         12'h6C0
`define SAPSEL_TH_7_8         12'h7C0
`define SAPSEL_TH_8_9         12'h8F0
`define SAPSEL_TH_9_10        12'hA60
`define SAPSEL_TH_10_11       12'hBF8
`define SAPSEL_TH_OPEN        12'hDE0

// ==========================================================
// timing
`define SAPSEL_CLK_MHZ        250
`define SAPSEL_STARTUP_US     20
`define SAPSEL_STARTUP_CYC    (`SAPSEL_STARTUP_US * `SAPSEL_CLK_MHZ)
`define SAPSEL_SETTLE_NS      400
`define SAPSEL_SETTLE_CYC     ((`SAPSEL_SETTLE_NS * `SAPSEL_CLK_MHZ) / 1000)

`endif

// ==== sapsel_pkg.sv ====
`default_nettype none

package sapsel_pkg;
  typedef enum logic [2:0] {
    SAPSEL_ST_DELAY,
    SAPSEL_ST_BIAS,
    SAPSEL_ST_CONV,
    SAPSEL_ST_WAIT,
    SAPSEL_ST_RUN
  } sapsel_state_t;

  typedef enum logic [1:0] {
    SAPSEL_BIN_OK,
    SAPSEL_BIN_SHORT,
    SAPSEL_BIN_OPEN
  } sapsel_bin_t;
endpackage

`default_nettype wire

// ==== sapsel_bin_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sapsel_params.svh"

module sapsel_bin_decode (
  input  wire logic [11:0]          code,
  output logic      [3:0]           digit,
  output sapsel_pkg::sapsel_bin_t   status
);
  import sapsel_pkg::*;

  // ==========================================================
  // thresholds, ascending
  localparam logic [11:0] TH [0:10] = '{
    `SAPSEL_TH_0_1, `SAPSEL_TH_1_2, `SAPSEL_TH_2_3, `SAPSEL_TH_3_4,
    `SAPSEL_TH_4_5, `SAPSEL_TH_5_6, `SAPSEL_TH_6_7, `SAPSEL_TH_7_8,
    `SAPSEL_TH_8_9, `SAPSEL_TH_9_10, `SAPSEL_TH_10_11};

  // ==========================================================
  // larger code gives larger digit
  always_comb begin
    digit = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (code >= TH[i]) begin
        digit = 4'(i + 1);
      end
    end
    if (code < `SAPSEL_TH_SHORT) begin
      status = SAPSEL_BIN_SHORT;
    end else if (code > `SAPSEL_TH_OPEN) begin
      status = SAPSEL_BIN_OPEN;
    end else begin
      status = SAPSEL_BIN_OK;
    end
  end
endmodule

`default_nettype wire

// ==== sapsel_addr_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sapsel_params.svh"

module sapsel_addr_select (
  input  wire logic [11:0]          code_hi,
  input  wire logic [11:0]          code_lo,
  output logic      [6:0]           addr,
  output logic                      strap_bad
);
  import sapsel_pkg::*;

  logic        [3:0]  digit_hi;
  logic        [3:0]  digit_lo;
  sapsel_bin_t        stat_hi;
  sapsel_bin_t        stat_lo;
  logic        [6:0]  sum;

  sapsel_bin_decode u_hi (
    .code   (code_hi),
    .digit  (digit_hi),
    .status (stat_hi)
  );

  sapsel_bin_decode u_lo (
    .code   (code_lo),
    .digit  (digit_lo),
    .status (stat_lo)
  );

  // ==========================================================
  // address combine with fallback
  always_comb begin
    sum       = 7'(`SAPSEL_ADDR_MULT * {3'h0, digit_hi}) + {3'h0, digit_lo};
    strap_bad = (stat_hi != SAPSEL_BIN_OK) || (stat_lo != SAPSEL_BIN_OK);
    addr      = strap_bad ? `SAPSEL_ADDR_FALLBACK : sum;
  end
endmodule

`default_nettype wire

// ==== sapsel_strap_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// strap resistors and converter on the far side of the pins
module sapsel_strap_model (
  input  wire logic        ref_clk,
  input  wire logic        adc_start,
  input  wire logic        adc_sel_hi,
  input  wire logic        bias_en_hi,
  input  wire logic        bias_en_lo,
  input  wire logic [11:0] code_hi,
  input  wire logic [11:0] code_lo,
  input  wire logic [4:0]  lat,
  output logic             adc_done,
  output logic      [11:0] adc_code
);
  logic [4:0]  cnt;
  logic        busy;
  logic [11:0] held;

  initial begin
    busy     = 1'b0;
    adc_done = 1'b0;
    adc_code = 12'hA5A;
  end

  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    // code seen between results toggles, so a stale read shows up
    adc_code <= ~adc_code;
    if (adc_start && !busy) begin
      busy <= 1'b1;
      cnt  <= lat;
      // no bias current means the pin sits near ground
      held <= adc_sel_hi ? (bias_en_hi ? code_hi : 12'h000) : (bias_en_lo ? code_lo : 12'h000);
    end else if (busy) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h00) begin
        busy     <= 1'b0;
        adc_done <= 1'b1;
        adc_code <= held;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sapsel_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
  import sapsel_pkg::*;
  logic        ref_clk, rst_n, external_reset_low_input, supply_above_threshold, flash_blank, bootload_cmd;
  logic        bias_en_hi, bias_en_lo, adc_start, adc_sel_hi, adc_done, addr_valid, debug_port_en;
  logic        shared_pins_func, run, valid_q;
  logic [11:0] adc_code, code_hi, code_lo;
  logic [6:0]  bus_addr;
  logic [4:0]  lat;
  logic [7:0]  note;
  logic [7:0]  notes [$];
  logic [11:0] th [13];
  int          n_mismatch, samples_checked, cycles, hi, lo, a;

  sapsel_startup #(.STARTUP_CYC(16)) u_sapsel_startup (.ref_clk(ref_clk), .rst_n(rst_n),
    .external_reset_low_input(external_reset_low_input), .supply_above_threshold(supply_above_threshold),
    .flash_blank(flash_blank), .bootload_cmd(bootload_cmd), .bias_en_hi(bias_en_hi), .bias_en_lo(bias_en_lo),
    .adc_start(adc_start), .adc_sel_hi(adc_sel_hi), .adc_done(adc_done), .adc_code(adc_code),
    .bus_addr(bus_addr), .addr_valid(addr_valid), .debug_port_en(debug_port_en),
    .shared_pins_func(shared_pins_func), .run(run));

  sapsel_strap_model u_sapsel_strap_model (.ref_clk(ref_clk), .adc_start(adc_start), .adc_sel_hi(adc_sel_hi),
    .bias_en_hi(bias_en_hi), .bias_en_lo(bias_en_lo), .code_hi(code_hi), .code_lo(code_lo), .lat(lat),
    .adc_done(adc_done), .adc_code(adc_code));

  // ==========================================================
  // clock, timeout and verdict
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      `CHK(cycles, 0)
      complete_run();
    end
  end

  // ==========================================================
  // stimulus; digit -1 is a short, 12 an open pin
  function automatic logic [11:0] bin_code(int d);
    if (d < 0) return 12'($urandom % th[0]);
    if (d > 11) return 12'(th[12] + 1 + $urandom % (12'hFFF - th[12]));
    return 12'(th[d] + 1 + $urandom % (th[d+1] - th[d] - 1));
  endfunction

  task automatic startup(int h, int l, logic bl, logic early_boot, logic by_supply);
    logic       bad;
    logic [6:0] exp_addr;
    int         w;
    bad      = (h < 0 || h > 11 || l < 0 || l > 11);
    exp_addr = bad ? 7'h7E : 7'(12 * h + l);
    @(posedge ref_clk);
    #1;
    code_hi = bin_code(h);
    code_lo = bin_code(l);
    lat     = 5'($urandom_range(1, 20));
    flash_blank = bl;
    if (by_supply) supply_above_threshold = 1'b0;
    else external_reset_low_input = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(bus_addr, 7'h7E)
    `CHK(addr_valid | run | debug_port_en, 1'b0)
    external_reset_low_input = 1'b1;
    supply_above_threshold   = 1'b1;
    notes.push_back({bad | bl, exp_addr});
    if (early_boot) begin
      bootload_cmd = 1'b1;
      @(posedge ref_clk);
      #1;
      bootload_cmd = 1'b0;
    end
    w = 0;
    while (addr_valid !== 1'b1 && w < 2000) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    if (w >= 2000) begin
      `CHK(w, 0)
      complete_run();
    end
    `CHK(w > 216 + 2 * lat, 1'b1)
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(bus_addr, exp_addr)
  endtask

  // ==========================================================
  // watcher: each new address is taken against the oldest note
  always @(negedge ref_clk) begin
    if (adc_start === 1'b1) `CHK(adc_sel_hi ? bias_en_hi : bias_en_lo, 1'b1)
    if (addr_valid === 1'b1 && valid_q !== 1'b1) begin
      if (notes.size() == 0) `CHK(notes.size(), 1)
      else begin
        note = notes.pop_front();
        `CHK(bus_addr, note[6:0])
        `CHK(debug_port_en, note[7])
        `CHK(shared_pins_func, ~note[7])
        `CHK(run, 1'b1)
      end
    end
    valid_q = addr_valid;
  end

  initial begin
    th = '{`SAPSEL_TH_SHORT, `SAPSEL_TH_0_1, `SAPSEL_TH_1_2, `SAPSEL_TH_2_3, `SAPSEL_TH_3_4, `SAPSEL_TH_4_5,
           `SAPSEL_TH_5_6, `SAPSEL_TH_6_7, `SAPSEL_TH_7_8, `SAPSEL_TH_8_9, `SAPSEL_TH_9_10, `SAPSEL_TH_10_11,
           `SAPSEL_TH_OPEN};
    void'($urandom(32'h2fe26e3b));
    rst_n = 1'b0;
    external_reset_low_input = 1'b1;
    supply_above_threshold = 1'b1;
    flash_blank = 1'b0;
    bootload_cmd = 1'b0;
    code_hi = 12'h000;
    code_lo = 12'h000;
    lat = 5'h01;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // straps stay clear of 0, 11, 12 and anything above 125
    for (int d = 0; d < 12; d++) startup(2, d, 1'b0, 1'b0, 1'b0);
    for (int d = 0; d < 11; d++) startup(d, 1, 1'b0, 1'b0, 1'b0);
    startup(-1, 5, 1'b0, 1'b0, 1'b0);
    startup(5, -1, 1'b0, 1'b0, 1'b1);
    startup(12, 3, 1'b0, 1'b0, 1'b0);
    startup(3, 12, 1'b0, 1'b0, 1'b1);
    startup(4, 4, 1'b1, 1'b0, 1'b0);
    startup(4, 4, 1'b0, 1'b1, 1'b1);
    bootload_cmd = 1'b1;
    @(posedge ref_clk);
    #1;
    bootload_cmd = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(debug_port_en, 1'b1)
    `CHK(bus_addr, 7'h34)
    repeat (6) begin
      do begin
        hi = $urandom % 11;
        lo = $urandom % 12;
        a  = 12 * hi + lo;
      end while (a == 0 || a == 11 || a == 12 || a > 125);
      startup(hi, lo, 1'b0, 1'b0, 1'($urandom % 2));
    end
    external_reset_low_input = 1'b0;
    @(posedge ref_clk);
    #1;
    external_reset_low_input = 1'b1;
    repeat (120) @(posedge ref_clk);
    #1;
    `CHK(addr_valid, 1'b0)
    startup(7, 9, 1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
